/* hw/bcg_pkg.sv */
// constants shared by the back-channel pin and frame pulse block
`default_nettype none
package bcg_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ADDR_PIN_STATUS = 8'h0E;
  localparam logic [7:0] ADDR_INPUT_CTL  = 8'h0F;
  localparam logic [7:0] ADDR_PIN_FUNC0  = 8'h10;
  localparam logic [7:0] ADDR_FP_CTL     = 8'h18;
  localparam logic [7:0] ADDR_FP_HIGH_U  = 8'h19;
  localparam logic [7:0] ADDR_FP_HIGH_L  = 8'h1A;
  localparam logic [7:0] ADDR_FP_LOW_U   = 8'h1B;
  localparam logic [7:0] ADDR_FP_LOW_L   = 8'h1C;
  localparam logic [7:0] ADDR_PORT_SEL   = 8'h4C;
  localparam logic [7:0] ADDR_RATE       = 8'h58;
  localparam logic [7:0] ADDR_MAP_A      = 8'h6E;
  localparam logic [7:0] ADDR_MAP_B      = 8'h6F;
  localparam logic [7:0] ADDR_PULLDOWN   = 8'hBE;
  // ****************************************
  // sizes and field positions
  // ****************************************
  localparam int NUM_PINS  = 4;
  localparam int NUM_PORTS = 2;
  localparam int FP_ON_BIT    = 0;
  localparam int FP_DUTY_BIT  = 1;
  localparam int FP_START_BIT = 2;
  localparam int FP_SRC_LSB   = 4;
  localparam int PF_OE_BIT    = 0;
  localparam int PF_VAL_BIT   = 1;
  localparam int PF_FP_BIT    = 2;
  localparam int PSEL_WR_LSB  = 0;
  localparam int PSEL_RD_BIT  = 4;
  localparam logic [3:0] SRC_EXT_FIRST   = 4'h8;
  localparam logic [3:0] SRC_EXT_LAST    = 4'hB;
  localparam logic [3:0] SRC_PORT1       = 4'h1;
  localparam logic [3:0] MAP_FRAME_PULSE = 4'hA;
  localparam logic [2:0] RATE_2M5        = 3'h0;
  localparam logic [2:0] RATE_5M         = 3'h1;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_REG      = 8'h00;
  localparam logic [7:0] RST_PORT_SEL = 8'h01;
  localparam logic [3:0] RST_ENABLES  = 4'hF;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS   = 10;
  localparam int FRAME_BITS      = 30;
  localparam int BIT_TIME_2M5_NS = 400;
  localparam int BIT_TIME_5M_NS  = 200;
  localparam logic [15:0] FRAME_CYCLES_2M5 = 16'(BIT_TIME_2M5_NS * FRAME_BITS / CLK_PERIOD_NS);
  localparam logic [15:0] FRAME_CYCLES_5M  = 16'(BIT_TIME_5M_NS * FRAME_BITS / CLK_PERIOD_NS);
endpackage
`default_nettype wire

/* hw/bcg_gpio_frame_sync.sv */
// back-channel pin routing, pin controls and frame pulse generator
`default_nettype none
module bcg_gpio_frame_sync
  import bcg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic [3:0] pinIn,
  output var  logic [7:0] regRdata,
  output var  logic       regReadValid,
  output var  logic [3:0] pinOut,
  output var  logic [3:0] pinOe,
  output var  logic [3:0] pinInputOn,
  output var  logic [3:0] pinPulldownOn,
  output var  logic [3:0] bcSignal0,
  output var  logic [3:0] bcSignal1,
  output var  logic       framePulse
);
  // ****************************************
  // pin synchroniser
  // ****************************************
  logic [3:0] pinMeta;
  logic [3:0] pinSync;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinMeta <= 4'h0;
      pinSync <= 4'h0;
    end else begin
      pinMeta <= pinIn;
      pinSync <= pinMeta;
    end
  end
  // a disabled input path feeds zero to the back channel, status still sees the pad
  wire logic [3:0] pinToBc = pinSync & pinInputOn;

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] pinFunc [NUM_PINS];
  logic [7:0] mapA [NUM_PORTS];
  logic [7:0] mapB [NUM_PORTS];
  logic [7:0] rate [NUM_PORTS];
  logic [7:0] fpCtl;
  logic [7:0] highU;
  logic [7:0] highL;
  logic [7:0] lowU;
  logic [7:0] lowL;
  logic [7:0] portSel;
  logic [7:0] rdData;

  wire logic wrCtl   = regWrite && (regAddr == ADDR_FP_CTL);
  wire logic wrHighU = regWrite && (regAddr == ADDR_FP_HIGH_U);
  wire logic wrHighL = regWrite && (regAddr == ADDR_FP_HIGH_L);
  wire logic wrLowU  = regWrite && (regAddr == ADDR_FP_LOW_U);
  wire logic wrLowL  = regWrite && (regAddr == ADDR_FP_LOW_L);
  wire logic wrPsel  = regWrite && (regAddr == ADDR_PORT_SEL);
  wire logic wrInput = regWrite && (regAddr == ADDR_INPUT_CTL);
  wire logic wrPd    = regWrite && (regAddr == ADDR_PULLDOWN);
  wire logic wrRate  = regWrite && (regAddr == ADDR_RATE);
  wire logic rdPort  = portSel[PSEL_RD_BIT];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fpCtl         <= RST_REG;
      highU         <= RST_REG;
      highL         <= RST_REG;
      lowU          <= RST_REG;
      lowL          <= RST_REG;
      portSel       <= RST_PORT_SEL;
      pinInputOn    <= RST_ENABLES;
      pinPulldownOn <= RST_ENABLES;
    end else begin
      if (wrCtl) fpCtl <= regWdata;
      if (wrHighU) highU <= regWdata;
      if (wrHighL) highL <= regWdata;
      if (wrLowU) lowU <= regWdata;
      if (wrLowL) lowL <= regWdata;
      if (wrPsel) portSel <= regWdata;
      // stored as enables; software writes disable bits
      if (wrInput) pinInputOn <= ~regWdata[3:0];
      if (wrPd) pinPulldownOn <= ~regWdata[3:0];
    end
  end

  // ****************************************
  // per-port registers, write mask from port select
  // ****************************************
  logic [15:0] tickCnt [NUM_PORTS];
  logic [NUM_PORTS-1:0] tick;
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : gPort
      wire logic sel = portSel[PSEL_WR_LSB + p];
      wire logic wrA = regWrite && sel && (regAddr == ADDR_MAP_A);
      wire logic wrB = regWrite && sel && (regAddr == ADDR_MAP_B);
      wire logic wrR = wrRate && sel;
      wire logic [15:0] period = (rate[p][2:0] == RATE_5M) ? FRAME_CYCLES_5M : FRAME_CYCLES_2M5;
      assign tick[p] = (tickCnt[p] == period - 16'h0001);
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          mapA[p]    <= RST_REG;
          mapB[p]    <= RST_REG;
          rate[p]    <= RST_REG;
          tickCnt[p] <= 16'h0000;
        end else begin
          if (wrA) mapA[p] <= regWdata;
          if (wrB) mapB[p] <= regWdata;
          if (wrR) rate[p] <= regWdata;
          // a rate change may shorten the period under a running count
          if (tick[p] || tickCnt[p] >= period) tickCnt[p] <= 16'h0000;
          else tickCnt[p] <= tickCnt[p] + 16'h0001;
        end
      end
    end
  endgenerate

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    rdData = 8'h00;
    if (regAddr == ADDR_PIN_STATUS) rdData = {4'h0, pinSync};
    else if (regAddr == ADDR_INPUT_CTL) rdData = {4'h0, ~pinInputOn};
    else if (regAddr[7:2] == ADDR_PIN_FUNC0[7:2]) rdData = pinFunc[regAddr[1:0]];
    else if (regAddr == ADDR_FP_CTL) rdData = fpCtl;
    else if (regAddr == ADDR_FP_HIGH_U) rdData = highU;
    else if (regAddr == ADDR_FP_HIGH_L) rdData = highL;
    else if (regAddr == ADDR_FP_LOW_U) rdData = lowU;
    else if (regAddr == ADDR_FP_LOW_L) rdData = lowL;
    else if (regAddr == ADDR_PORT_SEL) rdData = portSel;
    else if (regAddr == ADDR_RATE) rdData = rate[rdPort];
    else if (regAddr == ADDR_MAP_A) rdData = mapA[rdPort];
    else if (regAddr == ADDR_MAP_B) rdData = mapB[rdPort];
    else if (regAddr == ADDR_PULLDOWN) rdData = {4'h0, ~pinPulldownOn};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdata     <= 8'h00;
      regReadValid <= 1'b0;
    end else begin
      regRdata     <= regRead ? rdData : regRdata;
      regReadValid <= regRead;
    end
  end

  // ****************************************
  // frame pulse generator
  // ****************************************
  wire logic genOn = fpCtl[FP_ON_BIT];
  wire logic [3:0] srcSel = fpCtl[FP_SRC_LSB +: 4];
  wire logic genTick = (srcSel == SRC_PORT1) ? tick[1] : tick[0];
  wire logic [15:0] highCount = {highU, highL};
  wire logic [15:0] lowCount = {lowU, lowL};
  wire logic [16:0] sumCount = {1'b0, highCount} + {1'b0, lowCount};
  wire logic [15:0] halfCount = sumCount[16:1];
  logic genOnPrev;
  logic genLevel;
  logic [15:0] phaseCnt;
  wire logic start = genOn && !genOnPrev;
  // even duty splits the programmed period in two halves
  wire logic [15:0] phaseLen = fpCtl[FP_DUTY_BIT] ? halfCount : (genLevel ? highCount : lowCount);
  // a zero count still lasts one tick
  wire logic phaseEnd = genTick && (({1'b0, phaseCnt} + 17'h00001) >= {1'b0, phaseLen});

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      genOnPrev <= 1'b0;
      genLevel  <= 1'b0;
      phaseCnt  <= 16'h0000;
    end else begin
      genOnPrev <= genOn;
      if (start) begin
        genLevel <= fpCtl[FP_START_BIT];
        phaseCnt <= 16'h0000;
      end else if (genOn && phaseEnd) begin
        genLevel <= ~genLevel;
        phaseCnt <= 16'h0000;
      end else if (genOn && genTick) begin
        phaseCnt <= phaseCnt + 16'h0001;
      end
    end
  end

  wire logic extSel = !genOn && (srcSel >= SRC_EXT_FIRST) && (srcSel <= SRC_EXT_LAST);
  wire logic nextFramePulse = genOn ? genLevel : (extSel ? pinToBc[srcSel[1:0]] : 1'b0);

  // ****************************************
  // back-channel routing and pin drivers
  // ****************************************
  logic [7:0] next_bc;
  logic [7:0] bcReg;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gBc
      localparam int PORT = g / 4;
      localparam int SIG = g % 4;
      wire logic [7:0] mapReg = (SIG < 2) ? mapA[PORT] : mapB[PORT];
      wire logic [3:0] code = mapReg[4 * (SIG % 2) +: 4];
      assign next_bc[g] = (code == MAP_FRAME_PULSE) ? nextFramePulse :
                          (code < 4'h4) ? pinToBc[code[1:0]] : 1'b0;
    end
  endgenerate

  logic [3:0] next_pinOut;
  genvar i;
  generate
    for (i = 0; i < NUM_PINS; i++) begin : gPin
      wire logic wrF = regWrite && (regAddr == ADDR_PIN_FUNC0 + 8'(i));
      assign next_pinOut[i] = pinFunc[i][PF_FP_BIT] ? nextFramePulse : pinFunc[i][PF_VAL_BIT];
      always_ff @(posedge clk) begin
        if (!rst_n) pinFunc[i] <= RST_REG;
        else if (wrF) pinFunc[i] <= regWdata;
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bcReg      <= 8'h00;
      framePulse <= 1'b0;
      pinOut     <= 4'h0;
      pinOe      <= 4'h0;
    end else begin
      bcReg      <= next_bc;
      framePulse <= nextFramePulse;
      pinOut     <= next_pinOut;
      pinOe      <= {pinFunc[3][PF_OE_BIT], pinFunc[2][PF_OE_BIT], pinFunc[1][PF_OE_BIT], pinFunc[0][PF_OE_BIT]};
    end
  end
  assign bcSignal0 = bcReg[3:0];
  assign bcSignal1 = bcReg[7:4];

  // ****************************************
  // assertions
  // ****************************************
  logic [15:0] sinceTick;
  logic sinceValid;
  always_ff @(posedge clk) begin
    if (!rst_n || wrRate) begin
      sinceTick  <= 16'h0000;
      sinceValid <= 1'b0;
    end else begin
      sinceTick  <= tick[0] ? 16'h0000 : sinceTick + 16'h0001;
      sinceValid <= sinceValid | tick[0];
    end
  end

  tick_period_a: assert property (@(posedge clk) disable iff (!rst_n)
    tick[0] && sinceValid && rate[0][2:0] == RATE_2M5 |-> sinceTick == FRAME_CYCLES_2M5 - 16'h0001)
    else $error("port 0 frame tick period wrong");
  start_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    start && !wrCtl |=> ##1 framePulse == $past(fpCtl[FP_START_BIT], 2))
    else $error("frame pulse did not start at programmed level");
  ext_source_a: assert property (@(posedge clk) disable iff (!rst_n)
    !genOn && srcSel == SRC_EXT_FIRST |=> framePulse == $past(pinSync[0] & pinInputOn[0]))
    else $error("external frame pulse not taken from pin 0");
  route_aa_a: assert property (@(posedge clk) disable iff (!rst_n)
    mapA[0] == 8'hAA |=> bcSignal0[1:0] == {2{$past(nextFramePulse)}})
    else $error("frame pulse not routed to signals 0 and 1");
  pin_status_a: assert property (@(posedge clk) disable iff (!rst_n)
    regRead && regAddr == ADDR_PIN_STATUS |=> regReadValid && regRdata == {4'h0, $past(pinSync)})
    else $error("pin status read wrong");
  reset_enables_a: assert property (@(posedge clk)
    !rst_n |=> pinInputOn == 4'hF && pinPulldownOn == 4'hF)
    else $error("enables not set after reset");
  pd_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrPd |=> pinPulldownOn == ~$past(regWdata[3:0]))
    else $error("pulldown disable write not taken");
  phase_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    genOn && !start && !phaseEnd && !wrCtl |=> ##1 $stable(framePulse))
    else $error("frame pulse level changed mid phase");
  gen_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    fpCtl == 8'h00 |=> framePulse == 1'b0)
    else $error("frame pulse active with generator off");

  gen_toggle_c: cover property (@(posedge clk) disable iff (!rst_n) genOn ##1 $fell(genLevel));
  ext_mode_c: cover property (@(posedge clk) disable iff (!rst_n) extSel && framePulse);
  route_aa_c: cover property (@(posedge clk) disable iff (!rst_n) mapA[1] == 8'hAA && bcSignal1[0]);
endmodule
`default_nettype wire

/* verification/bcg_serializer_model.sv */
// remote serializer model: measures level runs on one back-channel line
`default_nettype none
module bcg_serializer_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic bcLine,
  output var  int   highLen,
  output var  int   lowLen
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // run length capture
  // ****************************************
  int   run;
  logic last;
  // a run is latched only when the line turns, so the bench must wait past the first partial phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run     <= 0;
      last    <= 1'b0;
      highLen <= 0;
      lowLen  <= 0;
    end else if (bcLine !== last) begin
      if (last) begin
        highLen <= run;
      end else begin
        lowLen <= run;
      end
      run  <= 1;
      last <= bcLine;
    end else begin
      run <= run + 1;
    end
  end
endmodule
`default_nettype wire

/* verification/bcg_gpio_frame_sync_tb_top.sv */
// self-checking bench for the back-channel pin and frame pulse block
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    nTests++; \
    if ((got) !== (exp)) begin \
      $display("unexpected %s: expected %h seen %h", nm, exp, got); \
      failures++; \
    end \
  end
module bcg_gpio_frame_sync_tb_top;
  import bcg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // signals
  // ****************************************
  localparam int TICK = 30 * 400 / 10;
  logic       clk;
  logic       rst_n;
  logic       regWrite;
  logic       regRead;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic [3:0] extPin;
  wire  logic [3:0] pinIn;
  logic [7:0] regRdata;
  logic       regReadValid;
  logic [3:0] pinOut;
  logic [3:0] pinOe;
  logic [3:0] pinInputOn;
  logic [3:0] pinPulldownOn;
  logic [3:0] bcSignal0;
  logic [3:0] bcSignal1;
  logic       framePulse;
  int         hiLen;
  int         loLen;
  int         failures = 0;
  int         nTests   = 0;
  // pad level: the block wins where it drives, the outside world elsewhere
  assign pinIn = (pinOe & pinOut) | (~pinOe & extPin);
  bcg_gpio_frame_sync bcg_gpio_frame_sync_i (
    .clk(clk), .rst_n(rst_n), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .pinIn(pinIn), .regRdata(regRdata),
    .regReadValid(regReadValid), .pinOut(pinOut), .pinOe(pinOe), .pinInputOn(pinInputOn),
    .pinPulldownOn(pinPulldownOn), .bcSignal0(bcSignal0), .bcSignal1(bcSignal1),
    .framePulse(framePulse)
  );
  bcg_serializer_model bcg_serializer_model_i (
    .clk(clk), .rst_n(rst_n), .bcLine(bcSignal0[0]), .highLen(hiLen), .lowLen(loLen)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ****************************************
  // bus tasks
  // ****************************************
  task automatic complete_run();
    if (failures == 0 && nTests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    int n;
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    for (n = 0; n < 4 && regReadValid !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 4) begin
      failures++;
      complete_run();
    end else
      `CHK("read data", exp, regRdata)
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic testReset();
    #1;
    `CHK("input enables", 4'hF, pinInputOn)
    `CHK("pulldown enables", 4'hF, pinPulldownOn)
    rdChk(ADDR_FP_CTL, 8'h00);
    rdChk(ADDR_MAP_A, 8'h00);
    wr(8'h77, 8'h5A);
    rdChk(8'h77, 8'h00);
  endtask
  task automatic testRouting();
    @(posedge clk);
    extPin <= 4'h5;
    wr(ADDR_PORT_SEL, 8'h01);
    wr(ADDR_MAP_A, 8'h10);
    wr(ADDR_MAP_B, 8'h32);
    wr(ADDR_PORT_SEL, 8'h02);
    wr(ADDR_MAP_A, 8'h22);
    wr(ADDR_MAP_B, 8'h22);
    settle(4);
    `CHK("port 0 signals", 4'h5, bcSignal0)
    `CHK("port 1 fan-out", 4'hF, bcSignal1)
    rdChk(ADDR_MAP_A, 8'h10);
    rdChk(ADDR_PIN_STATUS, 8'h05);
    wr(ADDR_INPUT_CTL, 8'h04);
    wr(ADDR_PULLDOWN, 8'h09);
    settle(4);
    `CHK("input disabled", 4'hB, pinInputOn)
    `CHK("pulldown disabled", 4'h6, pinPulldownOn)
    `CHK("disabled path", 4'h0, bcSignal1)
    rdChk(ADDR_PIN_STATUS, 8'h05);
    wr(ADDR_INPUT_CTL, 8'h00);
    wr(ADDR_PULLDOWN, 8'h00);
    // pin 1 becomes an output driving high
    wr(ADDR_PIN_FUNC0 + 8'h01, 8'h03);
    settle(4);
    `CHK("driven pin", 4'h7, bcSignal0)
    `CHK("pin enables", 4'h2, pinOe)
    `CHK("pin values", 4'h2, pinOut)
    rdChk(ADDR_PIN_STATUS, 8'h07);
  endtask
  task automatic testExternal();
    logic [3:0] pad;
    pad = 4'h7;
    wr(ADDR_PORT_SEL, 8'h01);
    wr(ADDR_MAP_A, 8'hAA);
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_FP_CTL, {SRC_EXT_FIRST + 4'(p), 4'h0});
      settle(5);
      `CHK("external pulse", pad[p], framePulse)
      `CHK("pulse on signals", {2'b01, {2{pad[p]}}}, bcSignal0)
    end
  endtask
  task automatic testGenerator();
    wr(ADDR_RATE, {5'h00, RATE_2M5});
    wr(ADDR_FP_HIGH_U, 8'h00);
    wr(ADDR_FP_HIGH_L, 8'h02);
    wr(ADDR_FP_LOW_U, 8'h00);
    wr(ADDR_FP_LOW_L, 8'h03);
    wr(ADDR_FP_CTL, 8'h05);
    settle(3);
    `CHK("start level", 1'b1, framePulse)
    // pin 3 drives the pulse; the first high phase lasts at least one tick
    wr(ADDR_PIN_FUNC0 + 8'h03, 8'h05);
    settle(2);
    `CHK("pin frame pulse", 1'b1, pinOut[3])
    settle(3 * 5 * TICK);
    `CHK("high run", 2 * TICK, hiLen)
    `CHK("low run", 3 * TICK, loLen)
    wr(ADDR_FP_CTL, 8'h07);
    settle(3 * 4 * TICK);
    `CHK("even high", 2 * TICK, hiLen)
    `CHK("even low", 2 * TICK, loLen)
    // 5 Mbps halves the frame, so each half shrinks to two short frames
    wr(ADDR_RATE, 8'h01);
    settle(3 * 2 * TICK);
    `CHK("fast rate", TICK, hiLen)
    wr(ADDR_FP_CTL, 8'h17);
    settle(3 * 4 * TICK);
    `CHK("port 1 tick", 2 * TICK, loLen)
    // a high external level first, so a low start level is visible
    wr(ADDR_FP_CTL, 8'h88);
    settle(5);
    `CHK("external high", 1'b1, framePulse)
    wr(ADDR_FP_CTL, 8'h01);
    settle(3);
    `CHK("start level low", 1'b0, framePulse)
    wr(ADDR_FP_CTL, 8'h00);
    settle(4);
    `CHK("generator off", 1'b0, framePulse)
  endtask
  initial begin
    rst_n    = 1'b0;
    regWrite = 1'b0;
    regRead  = 1'b0;
    regAddr  = 8'h00;
    regWdata = 8'h00;
    extPin   = 4'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    testReset();
    testRouting();
    testExternal();
    testGenerator();
    complete_run();
  end
endmodule
`default_nettype wire
